// ---- rtl/dpg_pkg.sv ----
// constants, field layouts and carrier types for the digital pulse generators
package dpg_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // sizes and timing
   localparam int NUM_GEN          = 4;
   localparam int CNT_W            = 32;
   localparam int NUM_IO           = 3;
   localparam int SAMPLE_RATE_MHZ  = 125;
   localparam int SAMPLE_PERIOD_NS = 1000 / SAMPLE_RATE_MHZ;
   localparam int MIN_LENGTH       = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // register map
   localparam int          REG_ADDR_W     = 8;
   localparam logic [7:0]  GEN_BLOCK_MASK = 8'h80;
   localparam int          GEN_SEL_LSB    = 5;
   localparam logic [4:0]  OFS_LENGTH     = 5'h00;
   localparam logic [4:0]  OFS_WIDTH      = 5'h04;
   localparam logic [4:0]  OFS_DELAY      = 5'h08;
   localparam logic [4:0]  OFS_LOOPS      = 5'h0c;
   localparam logic [4:0]  OFS_CONFIG     = 5'h10;
   localparam logic [4:0]  OFS_STATE      = 5'h14;
   localparam logic [7:0]  ADDR_COMMAND   = 8'h80;
   localparam logic [7:0]  ADDR_STATUS    = 8'h84;
   localparam logic [7:0]  ADDR_IO_DIR    = 8'h88;

   // field positions
   localparam int CFG_MODE_LSB  = 0;
   localparam int CFG_SRC_LSB   = 4;
   localparam int CFG_GATE_LSB  = 8;
   localparam int STAT_BUSY_LSB = 0;
   localparam int STAT_OUT_LSB  = 4;
   localparam int STAT_IN_LSB   = 8;
   localparam int STATE_BUSY_BIT = 31;

   // reset values
   localparam logic [31:0] LENGTH_RST = 32'h0000_0002;
   localparam logic [31:0] WIDTH_RST  = 32'h0000_0001;
   localparam logic [31:0] DELAY_RST  = 32'h0000_0000;
   localparam logic [31:0] LOOPS_RST  = 32'h0000_0001;
   localparam logic [2:0]  IO_DIR_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // modes and selections
   typedef enum logic [1:0] {DPG_MODE_SINGLE, DPG_MODE_REPEAT, DPG_MODE_GATED} dpg_mode_type;

   typedef enum logic [3:0] {
      DPG_SRC_SW, DPG_SRC_CARD,
      DPG_SRC_GEN0, DPG_SRC_GEN1, DPG_SRC_GEN2, DPG_SRC_GEN3,
      DPG_SRC_IO1, DPG_SRC_IO2, DPG_SRC_IO3
   } dpg_src_type;

   typedef enum logic [1:0] {DPG_GATE_NONE, DPG_GATE_ARM, DPG_GATE_RUN} dpg_gate_type;

   typedef struct packed {
      dpg_mode_type      mode;
      dpg_src_type       src;
      dpg_gate_type      gate;
      logic [CNT_W-1:0]  length;
      logic [CNT_W-1:0]  width;
      logic [CNT_W-1:0]  delay;
      logic [CNT_W-1:0]  loops;
   } dpg_gen_cfg_type;

   typedef struct packed {
      logic                  wr;
      logic                  rd;
      logic [REG_ADDR_W-1:0] addr;
      logic [31:0]           wdata;
   } dpg_reg_req_type;

   typedef struct packed {
      logic armed;
      logic running;
      logic trigger;
   } dpg_card_type;

endpackage

// ---- rtl/dpg_sync.sv ----
// two-flop synchroniser for the asynchronous multi-purpose inputs
`timescale 1ns/1ps
module dpg_sync
   import dpg_pkg::*;
#(
   parameter int WIDTH = 3
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } dpg_sync_state_type;

   dpg_sync_state_type state_reg;
   dpg_sync_state_type state_next;

   always_comb
   begin
      state_next.stage1 = async_in;
      state_next.stage2 = state_reg.stage1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign sync_out = state_reg.stage2;

endmodule

// ---- rtl/dpg_channel.sv ----
// one pulse generator: delay, high time, low time and repeat count
`timescale 1ns/1ps
module dpg_channel
   import dpg_pkg::*;
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // setup
   input  dpg_gen_cfg_type       cfg,
   // control
   input  wire logic             start,
   input  wire logic             level,
   input  wire logic             enable,
   // results
   output logic                  pulse_out,
   output logic                  busy,
   output logic [CNT_W-1:0]      loops_left
);

   typedef enum logic [1:0] {DPG_PH_IDLE, DPG_PH_DELAY, DPG_PH_RUN} dpg_phase_type;

   typedef struct packed {
      dpg_phase_type    phase;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] pos;
      logic [CNT_W-1:0] loops;
      logic             out;
   } dpg_ch_state_type;

   dpg_ch_state_type state_reg;
   dpg_ch_state_type state_next;
   logic [CNT_W-1:0] last_pos;
   logic             gated;

   always_comb
   begin
      state_next = state_reg;
      gated      = (cfg.mode == DPG_MODE_GATED);
      // a length below the minimum is run as the minimum
      last_pos   = (cfg.length < CNT_W'(MIN_LENGTH)) ? CNT_W'(MIN_LENGTH - 1) : cfg.length - 1'b1;
      case (state_reg.phase)
         DPG_PH_IDLE:
         begin
            if (enable && (gated ? level : start))
            begin
               state_next.loops = (cfg.mode == DPG_MODE_SINGLE) ? CNT_W'(1) : cfg.loops;
               state_next.pos   = '0;
               if (cfg.delay == '0)
                  state_next.phase = DPG_PH_RUN;
               else
               begin
                  state_next.phase = DPG_PH_DELAY;
                  state_next.cnt   = cfg.delay - 1'b1;
               end
            end
         end
         DPG_PH_DELAY:
         begin
            if (state_reg.cnt == '0)
               state_next.phase = DPG_PH_RUN;
            else
               state_next.cnt = state_reg.cnt - 1'b1;
         end
         DPG_PH_RUN:
         begin
            if (state_reg.pos >= last_pos)
            begin
               state_next.pos = '0;
               // zero loops never terminates; gated runs until the level drops
               if (!gated && state_reg.loops == CNT_W'(1))
                  state_next.phase = DPG_PH_IDLE;
               else if (!gated && state_reg.loops != '0)
                  state_next.loops = state_reg.loops - 1'b1;
            end
            else
               state_next.pos = state_reg.pos + 1'b1;
         end
         default:
            state_next.phase = DPG_PH_IDLE;
      endcase
      // losing the gate cuts a pulse short rather than letting it finish
      if (state_reg.phase != DPG_PH_IDLE && (!enable || (gated && !level)))
         state_next.phase = DPG_PH_IDLE;
      state_next.out = (state_next.phase == DPG_PH_RUN) && (state_next.pos < cfg.width);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg       <= '0;
         state_reg.phase <= DPG_PH_IDLE;
      end
      else
         state_reg <= state_next;
   end

   assign pulse_out  = state_reg.out;
   assign busy       = (state_reg.phase != DPG_PH_IDLE);
   assign loops_left = state_reg.loops;

endmodule

// ---- rtl/dpg_top.sv ----
// four digital pulse generators with register port and multi-purpose line drive
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - four independent generators, each driving its own multi-purpose output line.
// - all timing counts sample clock periods, 8 ns at 125 MS/s.
// - modes are single shot, repeated pulses on trigger, and gated.
// - trigger from software, card trigger, another generator or an input line.
// - gate condition is none, card armed, or card running.
// - period length is 32 bits, programmable from 2 samples upward.
// - high time is 32 bits, programmable from 1 sample upward.
// - start delay after trigger is 32 bits, from 0 samples upward.
// - repeat count is 32 bits; zero repeats forever.
// - synchronous outputs update at the sample clock rate.
// - only lines one to three take input; line zero is output only.
module dpg_top
   import dpg_pkg::*;
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // register port
   input  dpg_reg_req_type       reg_req,
   output logic [31:0]           reg_rdata,
   // card state
   input  dpg_card_type          card,
   // multi-purpose line zero, output only
   output logic                  mp_output_line_zero,
   // multi-purpose line one
   input  wire logic             mp_io_line_one_in,
   output logic                  mp_io_line_one_out,
   output logic                  mp_io_line_one_oe,
   // multi-purpose line two
   input  wire logic             mp_io_line_two_in,
   output logic                  mp_io_line_two_out,
   output logic                  mp_io_line_two_oe,
   // multi-purpose line three
   input  wire logic             mp_io_line_three_in,
   output logic                  mp_io_line_three_out,
   output logic                  mp_io_line_three_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      dpg_gen_cfg_type [NUM_GEN-1:0] cfg;
      logic [NUM_IO-1:0]             io_dir;
      logic [NUM_GEN-1:0]            sw_trig;
      logic [NUM_GEN-1:0]            lvl_prev;
      logic [NUM_GEN-1:0]            line_out;
      logic [NUM_IO-1:0]             line_oe;
      logic [31:0]                   rdata;
   } dpg_top_state_type;

   dpg_top_state_type  state_reg;
   dpg_top_state_type  state_next;

   logic [NUM_IO-1:0]  multipurpose_io_lines;
   logic [NUM_GEN-1:0] gen_out;
   logic [NUM_GEN-1:0] gen_busy;
   logic [CNT_W-1:0]   gen_loops [NUM_GEN];
   logic [NUM_GEN-1:0] gen_level;
   logic [NUM_GEN-1:0] gen_start;
   logic [NUM_GEN-1:0] gen_enable;

   ////////////////////////////////////////////////////////////////////////////////
   // input lines are asynchronous, so they pass two flops before use

   dpg_sync #(
      .WIDTH    (NUM_IO)
   ) u_in_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({mp_io_line_three_in, mp_io_line_two_in, mp_io_line_one_in}),
      .sync_out (multipurpose_io_lines)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // trigger source and gate per generator

   function automatic logic src_level(
      input dpg_src_type        src,
      input logic               card_trig,
      input logic [NUM_GEN-1:0] outs,
      input logic [NUM_IO-1:0]  ins
   );
      logic lv;
      lv = 1'b0;
      case (src)
         DPG_SRC_CARD: lv = card_trig;
         DPG_SRC_GEN0: lv = outs[0];
         DPG_SRC_GEN1: lv = outs[1];
         DPG_SRC_GEN2: lv = outs[2];
         DPG_SRC_GEN3: lv = outs[3];
         DPG_SRC_IO1:  lv = ins[0];
         DPG_SRC_IO2:  lv = ins[1];
         DPG_SRC_IO3:  lv = ins[2];
         default:      lv = 1'b0;
      endcase
      return lv;
   endfunction

   always_comb
   begin
      for (int g = 0; g < NUM_GEN; g++)
      begin
         gen_level[g] = src_level(state_reg.cfg[g].src, card.trigger, gen_out, multipurpose_io_lines);
         // software start is already a one-cycle pulse; others start on a rising edge
         if (state_reg.cfg[g].src == DPG_SRC_SW)
            gen_start[g] = state_reg.sw_trig[g];
         else
            gen_start[g] = gen_level[g] && !state_reg.lvl_prev[g];
         case (state_reg.cfg[g].gate)
            DPG_GATE_NONE: gen_enable[g] = 1'b1;
            DPG_GATE_ARM:  gen_enable[g] = card.armed;
            DPG_GATE_RUN:  gen_enable[g] = card.running;
            default:       gen_enable[g] = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // generators

   for (genvar g = 0; g < NUM_GEN; g++)
   begin : gen_ch
      dpg_channel u_ch (
         .clk        (clk),
         .rst_n      (rst_n),
         .cfg        (state_reg.cfg[g]),
         .start      (gen_start[g]),
         .level      (gen_level[g]),
         .enable     (gen_enable[g]),
         .pulse_out  (gen_out[g]),
         .busy       (gen_busy[g]),
         .loops_left (gen_loops[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register port, line drive and next state

   logic [1:0]  sel;
   logic [4:0]  ofs;
   logic        in_gen;
   logic [31:0] rd_val;

   always_comb
   begin
      state_next          = state_reg;
      sel                 = reg_req.addr[GEN_SEL_LSB +: 2];
      ofs                 = reg_req.addr[4:0];
      in_gen              = (reg_req.addr & GEN_BLOCK_MASK) == 8'h00;
      rd_val              = 32'h0000_0000;
      state_next.sw_trig  = '0;
      state_next.lvl_prev = gen_level;

      // writes; unmapped addresses are ignored
      if (reg_req.wr)
      begin
         if (in_gen)
         begin
            case (ofs)
               OFS_LENGTH: state_next.cfg[sel].length = reg_req.wdata;
               OFS_WIDTH:  state_next.cfg[sel].width  = reg_req.wdata;
               OFS_DELAY:  state_next.cfg[sel].delay  = reg_req.wdata;
               OFS_LOOPS:  state_next.cfg[sel].loops  = reg_req.wdata;
               OFS_CONFIG:
               begin
                  state_next.cfg[sel].mode = dpg_mode_type'(reg_req.wdata[CFG_MODE_LSB +: 2]);
                  state_next.cfg[sel].src  = dpg_src_type'(reg_req.wdata[CFG_SRC_LSB +: 4]);
                  state_next.cfg[sel].gate = dpg_gate_type'(reg_req.wdata[CFG_GATE_LSB +: 2]);
               end
               default: ;
            endcase
         end
         else if (reg_req.addr == ADDR_COMMAND)
            state_next.sw_trig = reg_req.wdata[NUM_GEN-1:0];
         else if (reg_req.addr == ADDR_IO_DIR)
            state_next.io_dir = reg_req.wdata[NUM_IO-1:0];
      end

      // reads answer in the next cycle only
      if (reg_req.rd)
      begin
         if (in_gen)
         begin
            case (ofs)
               OFS_LENGTH: rd_val = state_reg.cfg[sel].length;
               OFS_WIDTH:  rd_val = state_reg.cfg[sel].width;
               OFS_DELAY:  rd_val = state_reg.cfg[sel].delay;
               OFS_LOOPS:  rd_val = state_reg.cfg[sel].loops;
               OFS_CONFIG:
               begin
                  rd_val[CFG_MODE_LSB +: 2] = state_reg.cfg[sel].mode;
                  rd_val[CFG_SRC_LSB +: 4]  = state_reg.cfg[sel].src;
                  rd_val[CFG_GATE_LSB +: 2] = state_reg.cfg[sel].gate;
               end
               OFS_STATE:
               begin
                  rd_val                 = gen_loops[sel];
                  rd_val[STATE_BUSY_BIT] = gen_busy[sel];
               end
               default: rd_val = 32'h0000_0000;
            endcase
         end
         else if (reg_req.addr == ADDR_STATUS)
         begin
            rd_val[STAT_BUSY_LSB +: NUM_GEN] = gen_busy;
            rd_val[STAT_OUT_LSB +: NUM_GEN]  = state_reg.line_out;
            rd_val[STAT_IN_LSB +: NUM_IO]    = multipurpose_io_lines;
         end
         else if (reg_req.addr == ADDR_IO_DIR)
            rd_val[NUM_IO-1:0] = state_reg.io_dir;
      end
      state_next.rdata = rd_val;

      // lines follow their generator every sample clock
      state_next.line_out = gen_out;
      state_next.line_oe  = state_reg.io_dir;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg        <= '0;
         state_reg.io_dir <= IO_DIR_RST;
         for (int g = 0; g < NUM_GEN; g++)
         begin
            state_reg.cfg[g].length <= LENGTH_RST;
            state_reg.cfg[g].width  <= WIDTH_RST;
            state_reg.cfg[g].delay  <= DELAY_RST;
            state_reg.cfg[g].loops  <= LOOPS_RST;
            state_reg.cfg[g].mode   <= DPG_MODE_SINGLE;
            state_reg.cfg[g].src    <= DPG_SRC_SW;
            state_reg.cfg[g].gate   <= DPG_GATE_NONE;
         end
      end
      else
         state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_rdata            = state_reg.rdata;
   assign mp_output_line_zero  = state_reg.line_out[0];
   assign mp_io_line_one_out   = state_reg.line_out[1];
   assign mp_io_line_one_oe    = state_reg.line_oe[0];
   assign mp_io_line_two_out   = state_reg.line_out[2];
   assign mp_io_line_two_oe    = state_reg.line_oe[1];
   assign mp_io_line_three_out = state_reg.line_out[3];
   assign mp_io_line_three_oe  = state_reg.line_oe[2];

endmodule

// ---- tb/dpg_assertions.sv ----
// assertion checker on the pulse generator top ports
`timescale 1ns/1ps
module dpg_assertions
   import dpg_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // register port
   input dpg_reg_req_type  reg_req,
   input wire logic [31:0] reg_rdata,
   // lines
   input wire logic        mp_output_line_zero,
   input wire logic        mp_io_line_one_oe,
   input wire logic        mp_io_line_two_oe,
   input wire logic        mp_io_line_three_oe
);
   typedef struct packed {
      logic [31:0] w0;
      logic [31:0] len0;
      logic [31:0] hi;
      logic [31:0] lo;
      logic [1:0]  mode0;
      logic [2:0]  dir;
   } dpg_chk_type;
   dpg_chk_type st_reg;
   dpg_chk_type st_next;
   logic [2:0]  oe;
   logic        dir_wr;
   logic        ok0;
   assign oe     = {mp_io_line_three_oe, mp_io_line_two_oe, mp_io_line_one_oe};
   assign dir_wr = reg_req.wr && reg_req.addr == ADDR_IO_DIR;
   // run lengths only mean something while gating cannot cut a pulse short
   assign ok0    = st_reg.w0 != 32'h0 && st_reg.w0 < st_reg.len0 && st_reg.mode0 != DPG_MODE_GATED;
   always_comb
   begin
      st_next    = st_reg;
      st_next.hi = mp_output_line_zero ? st_reg.hi + 32'h1 : 32'h0;
      st_next.lo = mp_output_line_zero ? 32'h0 : st_reg.lo + 32'h1;
      if (reg_req.wr)
      begin
         case (reg_req.addr)
            {3'h0, OFS_LENGTH}: st_next.len0 = reg_req.wdata;
            {3'h0, OFS_WIDTH}:  st_next.w0 = reg_req.wdata;
            {3'h0, OFS_CONFIG}: st_next.mode0 = reg_req.wdata[1:0];
            ADDR_IO_DIR:        st_next.dir = reg_req.wdata[2:0];
            default:            st_next.dir = st_reg.dir;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '{WIDTH_RST, LENGTH_RST, 32'h0, 32'h0, 2'h0, IO_DIR_RST};
      else
         st_reg <= st_next;
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_rdata_idle_zero:
      assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0) else $error("read data not zero when idle");
   chk_command_reads_zero:
      assert property (reg_req.rd && reg_req.addr == ADDR_COMMAND |=> reg_rdata == 32'h0)
         else $error("command word read not zero");
   chk_unmapped_reads_zero:
      assert property (reg_req.rd && (reg_req.addr >= 8'h8c || (!reg_req.addr[7] && reg_req.addr[4:2] > 3'h5))
         |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
   chk_dir_read_back:
      assert property (reg_req.rd && reg_req.addr == ADDR_IO_DIR |=> reg_rdata == {29'h0, $past(st_reg.dir)})
         else $error("direction read back wrong");
   chk_oe_follows_dir:
      assert property (dir_wr |=> ##1 oe == $past(reg_req.wdata[2:0], 2)) else $error("enables do not follow direction");
   chk_oe_holds_still:
      assert property (!$past(dir_wr, 2) |-> $stable(oe)) else $error("enables moved without direction write");
   chk_line_zero_high_run:
      assert property ($fell(mp_output_line_zero) && ok0 |-> st_reg.hi == st_reg.w0) else $error("high run not width");
   chk_line_zero_high_cap:
      assert property (mp_output_line_zero && ok0 |-> st_reg.hi < st_reg.w0) else $error("high run over width");
   chk_line_zero_low_gap:
      assert property ($rose(mp_output_line_zero) && ok0 |-> st_reg.lo >= st_reg.len0 - st_reg.w0)
         else $error("low gap shorter than length minus width");
endmodule

// ---- tb/dpg_line_model.sv ----
// far-side equipment on lines one to three, with the pin pull-up
`timescale 1ns/1ps
module dpg_line_model
   import dpg_pkg::*;
(
   // design side
   input wire logic [NUM_IO-1:0] oe,
   input wire logic [NUM_IO-1:0] drv,
   // far side
   input wire logic [NUM_IO-1:0] ext_en,
   input wire logic [NUM_IO-1:0] ext_val,
   output logic     [NUM_IO-1:0] line
);
   // a line nobody drives floats high through its pull-up
   always_comb
   begin
      for (int i = 0; i < NUM_IO; i++)
         line[i] = oe[i] ? drv[i] : (ext_en[i] ? ext_val[i] : 1'b1);
   end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the four pulse generators
`timescale 1ns/1ps
module testbench;
   import dpg_pkg::*;
   logic            clk;
   logic            rst_n;
   dpg_reg_req_type reg_req;
   logic [31:0]     reg_rdata;
   dpg_card_type    card;
   logic [3:0]      outs;
   logic [2:0]      oe;
   logic [2:0]      line;
   logic [2:0]      ext_en;
   logic [2:0]      ext_val;
   logic [31:0]     v;
   int              err_count;
   int              samples_checked;
   int              f;
   int              h;
   int              r;
   dpg_top DUT (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .card(card),
      .mp_output_line_zero(outs[0]), .mp_io_line_one_in(line[0]), .mp_io_line_one_out(outs[1]),
      .mp_io_line_one_oe(oe[0]), .mp_io_line_two_in(line[1]), .mp_io_line_two_out(outs[2]),
      .mp_io_line_two_oe(oe[1]), .mp_io_line_three_in(line[2]), .mp_io_line_three_out(outs[3]),
      .mp_io_line_three_oe(oe[2]));
   dpg_line_model u_far (.oe(oe), .drv(outs[3:1]), .ext_en(ext_en), .ext_val(ext_val), .line(line));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk);
      reg_req <= '0;
      #1;
      v = reg_rdata;
   endtask
   function automatic logic [31:0] cf(dpg_mode_type m, dpg_src_type s, dpg_gate_type g);
      return {22'h0, g, s, 2'h0, m};
   endfunction
   task automatic setup(input int g, input logic [31:0] len, w, d, lp, c);
      wr({3'(g), OFS_LENGTH}, len);
      wr({3'(g), OFS_WIDTH}, w);
      wr({3'(g), OFS_DELAY}, d);
      wr({3'(g), OFS_LOOPS}, lp);
      wr({3'(g), OFS_CONFIG}, c);
   endtask
   // sample index k is the k-th edge after the call; counts into f, h, r
   task automatic mon(input int g, input int n);
      logic p;
      p = 1'b0;
      f = 0;
      h = 0;
      r = 0;
      for (int k = 1; k <= n; k++)
      begin
         @(posedge clk);
         #1;
         if (outs[g] === 1'b1)
         begin
            h++;
            r += !p;
            f = (f == 0) ? k : f;
         end
         p = outs[g] === 1'b1;
      end
      @(posedge clk);
   endtask
   task automatic fire(input dpg_src_type s);
      case (s)
         DPG_SRC_SW: wr(ADDR_COMMAND, 32'h8);
         DPG_SRC_CARD:
         begin
            @(posedge clk);
            card.trigger <= 1'b1;
            @(posedge clk);
            card.trigger <= 1'b0;
         end
         DPG_SRC_IO1, DPG_SRC_IO2, DPG_SRC_IO3:
         begin
            @(posedge clk);
            ext_val[s - DPG_SRC_IO1] <= 1'b1;
            repeat (3) @(posedge clk);
            ext_val <= 3'h0;
         end
         default: wr(ADDR_COMMAND, 32'h1 << (s - DPG_SRC_GEN0));
      endcase
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] rv [4];
      rv = '{LENGTH_RST, WIDTH_RST, DELAY_RST, LOOPS_RST};
      for (int g = 0; g < NUM_GEN; g++)
      begin
         for (int k = 0; k < 4; k++)
         begin
            rd({3'(g), 5'(k * 4)});
            chk("reset value", rv[k], v);
         end
         wr({3'(g), OFS_DELAY}, 32'hffff_ffff);
         rd({3'(g), OFS_DELAY});
         chk("delay full", 32'hffff_ffff, v);
         wr({3'(g), OFS_DELAY}, 32'h0);
      end
      rd(ADDR_COMMAND);
      chk("command read", 32'h0, v);
      rd(8'hfc);
      chk("unmapped read", 32'h0, v);
   endtask
   task automatic t_pulses();
      setup(0, 32'h5, 32'h2, 32'h3, 32'h1, cf(DPG_MODE_SINGLE, DPG_SRC_SW, DPG_GATE_NONE));
      wr(ADDR_COMMAND, 32'h1);
      mon(0, 30);
      chk("first high", 32'h5, 32'(f));
      chk("high time", 32'h2, 32'(h));
      chk("single shot", 32'h1, 32'(r));
      // second start lands while busy and must be ignored
      setup(1, 32'h2, 32'h1, 32'h1, 32'h3, cf(DPG_MODE_REPEAT, DPG_SRC_SW, DPG_GATE_NONE));
      wr(ADDR_COMMAND, 32'h2);
      wr(ADDR_COMMAND, 32'h2);
      mon(1, 20);
      chk("repeat first", 32'h1, 32'(f));
      chk("repeat count", 32'h3, 32'(r));
      setup(2, 32'h4, 32'h2, 32'h0, 32'h0, cf(DPG_MODE_REPEAT, DPG_SRC_SW, DPG_GATE_NONE));
      wr(ADDR_COMMAND, 32'h4);
      mon(2, 40);
      chk("endless count", 32'ha, 32'(r));
      chk("endless highs", 32'h14, 32'(h));
      rd({3'h2, OFS_STATE});
      chk("state busy", 32'h8000_0000, v);
      wr({3'h2, OFS_CONFIG}, cf(DPG_MODE_REPEAT, DPG_SRC_SW, DPG_GATE_ARM));
      mon(2, 3);
      mon(2, 10);
      chk("gate abort", 32'h0, 32'(h));
   endtask
   task automatic t_gates();
      for (int i = 1; i <= 2; i++)
      begin
         wr({3'h1, OFS_LOOPS}, 32'h1);
         wr({3'h1, OFS_CONFIG}, cf(DPG_MODE_SINGLE, DPG_SRC_SW, dpg_gate_type'(i)));
         wr(ADDR_COMMAND, 32'h2);
         mon(1, 10);
         chk("gate shut", 32'h0, 32'(r));
         card.armed <= (i == 1);
         card.running <= (i == 2);
         wr(ADDR_COMMAND, 32'h2);
         mon(1, 10);
         chk("gate open", 32'h1, 32'(r));
         card <= '0;
      end
   endtask
   task automatic t_sources();
      wr({3'h1, OFS_CONFIG}, cf(DPG_MODE_SINGLE, DPG_SRC_SW, DPG_GATE_NONE));
      wr({3'h2, OFS_LOOPS}, 32'h1);
      wr({3'h2, OFS_CONFIG}, cf(DPG_MODE_SINGLE, DPG_SRC_SW, DPG_GATE_NONE));
      for (int i = 0; i <= 8; i++)
      begin
         if (dpg_src_type'(i) != DPG_SRC_GEN3)
         begin
            wr({3'h3, OFS_CONFIG}, cf(DPG_MODE_SINGLE, dpg_src_type'(i), DPG_GATE_NONE));
            fire(dpg_src_type'(i));
            mon(3, 30);
            chk("source start", 32'h1, 32'(r));
         end
      end
   endtask
   task automatic t_gated();
      wr({3'h1, OFS_CONFIG}, cf(DPG_MODE_GATED, DPG_SRC_CARD, DPG_GATE_RUN));
      @(posedge clk);
      card.running <= 1'b1;
      card.trigger <= 1'b1;
      mon(1, 12);
      chk("gated runs", 32'h1, 32'(r >= 3));
      card.trigger <= 1'b0;
      mon(1, 3);
      mon(1, 10);
      chk("gated stop", 32'h0, 32'(h));
      card <= '0;
   endtask
   task automatic t_dir();
      wr({3'h3, OFS_CONFIG}, 32'h0);
      ext_val <= 3'h7;
      wr(ADDR_IO_DIR, 32'h7);
      rd(ADDR_IO_DIR);
      chk("direction", 32'h7, v);
      chk("driven lines", 32'h0, {29'h0, line});
      wr(ADDR_IO_DIR, 32'h0);
      repeat (3) @(posedge clk);
      #1;
      chk("released lines", 32'h7, {29'h0, line});
      rd(ADDR_STATUS);
      chk("status", 32'h700, v);
   endtask
   task automatic close_out();
      $display("mismatches %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      rst_n = 1'b0;
      reg_req = '0;
      card = '0;
      ext_en = 3'h7;
      ext_val = 3'h0;
      err_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_pulses();
      t_gates();
      t_sources();
      t_gated();
      t_dir();
      close_out();
   end
   // the whole run needs well under two thousand cycles
   initial
   begin
      #(8 * 20000);
      err_count++;
      close_out();
   end
endmodule
bind dpg_top dpg_assertions u_chk (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .mp_output_line_zero(mp_output_line_zero), .mp_io_line_one_oe(mp_io_line_one_oe),
   .mp_io_line_two_oe(mp_io_line_two_oe), .mp_io_line_three_oe(mp_io_line_three_oe));
